/* rtl/angle_sensor_spi_slave.sv */
`timescale 1ns/100ps
module angle_sensor_spi_slave #(
   parameter int unsigned CONV_CYCLES = angle_spi_pkg::CONV_WAIT_CYCLES
) (
   // Clock and reset
   input  wire logic        clk_sys,
   input  wire logic        rst_n,
   // SPI pins
   input  wire logic        sclk,
   input  wire logic        chipSelectN,
   input  wire logic        mosi,
   input  wire logic        misoIn,
   output logic             misoOut,
   output logic             misoOe,
   input  wire logic        wireModeSelect,
   // Measurement core
   input  wire logic [9:0]  angleIn,
   input  wire logic        alarmHiIn,
   input  wire logic        alarmLoIn,
   output logic             powerUp,
   output logic             measDoneN,
   // Status and settings
   output logic             frameErrorFlag,
   output logic [13:0]      errorStatus,
   output logic [5:0]       agcValue,
   output logic [7:0]       porOffValue,
   output logic [13:0]      sysConfig
);
   import angle_spi_pkg::*;

   // Elaboration checks on the timing settings
   if (CONV_CYCLES < 2) begin : g_convCheck
      $error("CONV_CYCLES must be at least 2");
   end
   if (SCLK_MIN_SAMPLES < 4) begin : g_sclkCheck
      $error("System clock too slow for serial clock");
   end

   // Pin synchronisers
   logic [4:0]  syncA_reg;
   logic [4:0]  syncB_reg;
   logic        sclkPrev_reg;
   logic        csPrev_reg;
   logic        sclkNow;
   logic        csNow;
   logic        sclkFall;
   logic        sclkRise;
   logic        csFall;
   logic        csRise;
   logic        rxBit;

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         syncA_reg    <= 5'h01;
         syncB_reg    <= 5'h01;
         sclkPrev_reg <= 1'b0;
         csPrev_reg   <= 1'b1;
      end else begin
         syncA_reg    <= {wireModeSelect, misoIn, mosi, sclk, chipSelectN};
         syncB_reg    <= syncA_reg;
         sclkPrev_reg <= sclkNow;
         csPrev_reg   <= csNow;
      end
   end

   assign csNow    = syncB_reg[0];
   assign sclkNow  = syncB_reg[1];
   assign sclkFall = sclkPrev_reg & ~sclkNow;
   assign sclkRise = ~sclkPrev_reg & sclkNow;
   assign csFall   = csPrev_reg & ~csNow;
   assign csRise   = ~csPrev_reg & csNow;
   assign rxBit    = syncB_reg[4] ? syncB_reg[2] : syncB_reg[3];

   // Receive shifter
   logic [15:0] rxShift_reg;
   logic [4:0]  bitCount_reg;

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         rxShift_reg  <= 16'h0000;
         bitCount_reg <= 5'h00;
      end else if (csFall) begin
         bitCount_reg <= 5'h00;
      end else if (!csNow && sclkFall) begin
         rxShift_reg  <= {rxShift_reg[14:0], rxBit};
         if (bitCount_reg != 5'h1f) begin
            bitCount_reg <= bitCount_reg + 5'h01;
         end
      end
   end

   // Frame decode
   cmdFrame_s   cmd;
   dataFrame_s  wrFrame;
   logic        frameOk;
   logic        parityOk;
   logic        expectData_reg;
   logic [13:0] pendingAddr_reg;
   logic [2:0]  errBits_reg;
   logic        errWow_reg;
   logic [13:0] angleData_reg;
   logic [5:0]  agc_reg;
   logic [7:0]  porOff_reg;
   logic [13:0] sysConfig_reg;
   logic [15:0] txWord_reg;
   logic        respRead_reg;
   measState_e  measState_reg;

   assign cmd      = cmdFrame_s'(rxShift_reg);
   assign wrFrame  = dataFrame_s'(rxShift_reg);
   assign frameOk  = (bitCount_reg == 5'd16);
   assign parityOk = (rxShift_reg[0] == ^rxShift_reg[15:1]);

   function automatic logic [15:0] makeFrame(input logic [13:0] d, input logic ef);
      makeFrame = {d, ef, ^{d, ef}};
   endfunction : makeFrame

   // Register read view for an address
   logic [13:0] rdData;
   logic        rdKnown;
   logic        wrAllowed;
   logic [13:0] errView;

   assign errView = {10'h000, errWow_reg, errBits_reg};

   always_comb begin
      rdData    = 14'h0000;
      rdKnown   = 1'b1;
      wrAllowed = 1'b0;
      if (cmd.addr == ADDR_ANGLE) begin
         rdData = angleData_reg;
      end else if (cmd.addr == ADDR_ERR_STATUS) begin
         rdData = errView;
      end else if (cmd.addr == ADDR_CLEAR_ERR) begin
         rdData = 14'h0000;
      end else if (cmd.addr == ADDR_AGC) begin
         rdData    = {8'h00, agc_reg};
         wrAllowed = 1'b1;
      end else if (cmd.addr == ADDR_POR_OFF) begin
         rdData    = {6'h00, porOff_reg};
         wrAllowed = 1'b1;
      end else if (cmd.addr == ADDR_SYS_CONFIG) begin
         rdData    = sysConfig_reg;
         wrAllowed = 1'b1;
      end else if (cmd.addr == ADDR_NOP) begin
         wrAllowed = 1'b1;
      end else begin
         rdKnown = 1'b0;
      end
   end

   // Frame-end actions
   logic        doStart;
   logic        doClear;
   logic        doWrite;
   logic [2:0]  errSet;
   logic        efOut;
   logic [15:0] txNext;
   logic [13:0] newValue;

   always_comb begin
      doStart  = 1'b0;
      doClear  = 1'b0;
      doWrite  = 1'b0;
      errSet   = 3'b000;
      newValue = 14'h0000;
      if (csRise) begin
         if (!frameOk) begin
            errSet[ERR_CLOCKS_POS] = 1'b1;
         end else if (!parityOk) begin
            errSet[ERR_PARITY_POS] = 1'b1;
         end else if (expectData_reg) begin
            doWrite = 1'b1;
         end else if (cmd.dirBit) begin
            if (!rdKnown) begin
               errSet[ERR_COMMAND_POS] = 1'b1;
            end else if (cmd.addr == ADDR_CLEAR_ERR) begin
               doClear = 1'b1;
            end else if (cmd.addr == ADDR_ANGLE) begin
               doStart = 1'b1;
            end
         end else if (!wrAllowed) begin
            errSet[ERR_COMMAND_POS] = 1'b1;
         end
      end
      if (pendingAddr_reg == ADDR_AGC) begin
         newValue = {8'h00, wrFrame.data[5:0]};
      end else if (pendingAddr_reg == ADDR_POR_OFF) begin
         newValue = {6'h00, wrFrame.data[7:0]};
      end else if (pendingAddr_reg == ADDR_SYS_CONFIG) begin
         newValue = wrFrame.data;
      end
      efOut  = doClear ? 1'b0 : ((|errBits_reg) | (|errSet));
      txNext = makeFrame(14'h0000, efOut);
      if (doWrite) begin
         txNext = makeFrame(newValue, efOut);
      end else if (doClear) begin
         txNext = 16'h0000;
      end else if (errSet == 3'b000) begin
         txNext = makeFrame(rdData, efOut);
      end
   end

   // Protocol state and error flags
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         expectData_reg  <= 1'b0;
         pendingAddr_reg <= 14'h0000;
         txWord_reg      <= 16'h0000;
         respRead_reg    <= 1'b0;
      end else if (csRise) begin
         expectData_reg  <= frameOk && parityOk && !expectData_reg
                            && !cmd.dirBit && wrAllowed;
         pendingAddr_reg <= cmd.addr;
         txWord_reg      <= txNext;
         respRead_reg    <= frameOk && !expectData_reg && cmd.dirBit;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         errBits_reg <= 3'b000;
      end else if (doClear) begin
         errBits_reg <= errSet;
      end else begin
         errBits_reg <= errBits_reg | errSet;
      end
   end

   // Writable settings
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         agc_reg       <= AGC_RESET;
         porOff_reg    <= POR_OFF_RESET;
         sysConfig_reg <= SYS_CONFIG_RESET;
      end else if (doWrite) begin
         if (pendingAddr_reg == ADDR_AGC) begin
            agc_reg <= wrFrame.data[5:0];
         end else if (pendingAddr_reg == ADDR_POR_OFF) begin
            porOff_reg <= wrFrame.data[7:0];
         end else if (pendingAddr_reg == ADDR_SYS_CONFIG) begin
            sysConfig_reg <= wrFrame.data;
         end
      end
   end

   // Measurement sequencing
   logic [31:0] measCount_reg;
   logic        measEnd;

   assign measEnd = (measState_reg == MEAS_RUN) && (measCount_reg == CONV_CYCLES - 1);

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         measState_reg <= MEAS_IDLE;
         measCount_reg <= 32'h0000_0000;
         powerUp       <= 1'b0;
         measDoneN     <= 1'b0;
         errWow_reg    <= 1'b0;
         angleData_reg <= 14'h0000;
      end else begin
         case (measState_reg)
            MEAS_IDLE: begin
               if (doStart) begin
                  measState_reg <= MEAS_RUN;
                  measCount_reg <= 32'h0000_0000;
                  powerUp       <= 1'b1;
                  measDoneN     <= 1'b1;
                  errWow_reg    <= 1'b1;
               end
            end
            MEAS_RUN: begin
               if (measEnd) begin
                  measState_reg <= MEAS_IDLE;
                  powerUp       <= 1'b0;
                  measDoneN     <= 1'b0;
                  errWow_reg    <= 1'b0;
                  angleData_reg <= {alarmLoIn, alarmHiIn, 2'b00, angleIn};
               end else begin
                  measCount_reg <= measCount_reg + 32'h0000_0001;
               end
            end
            default: begin
               measState_reg <= MEAS_IDLE;
            end
         endcase
      end
   end

   // Transmit path
   logic [15:0] txShift_reg;

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         txShift_reg <= 16'h0000;
         misoOut     <= 1'b0;
         misoOe      <= 1'b0;
      end else if (csFall) begin
         txShift_reg <= txWord_reg;
         misoOe      <= syncB_reg[4] | respRead_reg;
      end else if (csNow) begin
         misoOe      <= 1'b0;
      end else if (sclkRise) begin
         misoOut     <= txShift_reg[15];
         txShift_reg <= {txShift_reg[14:0], 1'b0};
      end
   end

   // Status outputs
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         frameErrorFlag <= 1'b0;
         errorStatus    <= 14'h0000;
         agcValue       <= AGC_RESET;
         porOffValue    <= POR_OFF_RESET;
         sysConfig      <= SYS_CONFIG_RESET;
      end else begin
         frameErrorFlag <= |errBits_reg;
         errorStatus    <= errView;
         agcValue       <= agc_reg;
         porOffValue    <= porOff_reg;
         sysConfig      <= sysConfig_reg;
      end
   end

   // Checks
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);

   sequence frameEnd;
      csRise && frameOk && parityOk;
   endsequence

   sequence measFinish;
      measEnd;
   endsequence

   miso_release_a: assert property (csRise |=> !misoOe)
      else $error("MISO still driven after frame end");
   meas_start_a: assert property (doStart && measState_reg == MEAS_IDLE
      |=> measDoneN && powerUp && errWow_reg)
      else $error("Angle read did not start measurement");
   meas_done_a: assert property (measFinish |=> !measDoneN && !errWow_reg)
      else $error("Measurement end not signalled");
   low_power_a: assert property ($fell(measDoneN) |-> !powerUp)
      else $error("Still powered after measurement");
   exec_at_end_a: assert property ($changed(txWord_reg) |-> $past(csRise))
      else $error("Response changed inside a frame");
   clock_count_a: assert property (csRise && !frameOk |=> errBits_reg[ERR_CLOCKS_POS]
      ##1 txWord_reg[1])
      else $error("Wrong clock count not flagged");
   tx_parity_a: assert property (txWord_reg[0] == ^txWord_reg[15:1])
      else $error("Response parity wrong");
   late_reply_a: assert property (csFall |=> txShift_reg == $past(txWord_reg))
      else $error("Response not loaded at frame start");
   parity_flag_a: assert property (csRise && frameOk && !parityOk
      |=> errBits_reg[ERR_PARITY_POS] && txWord_reg[1])
      else $error("Command parity error not flagged");
   angle_cmd_a: assert property (frameEnd ##0 (!expectData_reg && cmd.dirBit
      && cmd.addr == ADDR_ANGLE) |-> doStart)
      else $error("Angle read not recognised");

endmodule : angle_sensor_spi_slave

/* rtl/angle_spi_pkg.sv */
package angle_spi_pkg;

   localparam int          FRAME_BITS        = 16;
   localparam int          ADDR_W            = 14;
   localparam int          DATA_W            = 14;
   localparam int          ANGLE_W           = 10;
   localparam int          AGC_W             = 6;
   localparam int          POR_OFF_W         = 8;

   localparam logic [13:0] ADDR_ANGLE        = 14'h3fff;
   localparam logic [13:0] ADDR_CLEAR_ERR    = 14'h3380;
   localparam logic [13:0] ADDR_ERR_STATUS   = 14'h335a;
   localparam logic [13:0] ADDR_AGC          = 14'h3ff8;
   localparam logic [13:0] ADDR_POR_OFF      = 14'h3f22;
   localparam logic [13:0] ADDR_SYS_CONFIG   = 14'h3f20;
   localparam logic [13:0] ADDR_NOP          = 14'h0000;

   localparam logic [5:0]  AGC_RESET         = 6'h20;
   localparam logic [7:0]  POR_OFF_RESET     = 8'h00;
   localparam logic [13:0] SYS_CONFIG_RESET  = 14'h0000;

   localparam int          ALARM_HI_POS      = 12;
   localparam int          ALARM_LO_POS      = 13;
   localparam int          ERR_PARITY_POS    = 0;
   localparam int          ERR_COMMAND_POS   = 1;
   localparam int          ERR_CLOCKS_POS    = 2;
   localparam int          ERR_WOW_POS       = 3;

   localparam int          CLK_PERIOD_NS     = 10;
   localparam int          CONV_WAIT_US      = 500;
   localparam int          CONV_WAIT_CYCLES  = (CONV_WAIT_US * 1000) / CLK_PERIOD_NS;
   localparam int          SCLK_MIN_PERIOD_NS = 100;
   localparam int          SCLK_MIN_SAMPLES  = SCLK_MIN_PERIOD_NS / CLK_PERIOD_NS;

   typedef struct packed {
      logic              dirBit;
      logic [13:0]       addr;
      logic              evenCheckBit;
   } cmdFrame_s;

   typedef struct packed {
      logic [13:0]       data;
      logic              frameErrorFlag;
      logic              evenCheckBit;
   } dataFrame_s;

   typedef enum {MEAS_IDLE, MEAS_RUN} measState_e;

endpackage : angle_spi_pkg

/* tb/spi_host_model.sv */
`timescale 1ns/100ps
module spi_host_model (
   // Clock
   input  wire logic        clk_sys,
   // SPI pins
   output logic             sclk,
   output logic             chipSelectN,
   output logic             mosi,
   input  wire logic        misoLine,
   // Frame report
   output logic             frameDone,
   output logic [15:0]      rxWord
);
   initial begin
      sclk        = 1'b0;
      chipSelectN = 1'b1;
      mosi        = 1'b0;
      frameDone   = 1'b0;
      rxWord      = '0;
   end

   // One frame, mode 1, 160 ns serial clock
   task automatic xfer(input logic [15:0] tx, input int nBits);
      chipSelectN = 1'b0;
      repeat (8) @(negedge clk_sys);
      for (int i = 0; i < nBits; i++) begin
         sclk = 1'b1;
         mosi = tx[15-i];
         repeat (8) @(negedge clk_sys);
         rxWord = {rxWord[14:0], misoLine};
         sclk   = 1'b0;
         repeat (8) @(negedge clk_sys);
      end
      chipSelectN = 1'b1;
      frameDone   = 1'b1;
      @(negedge clk_sys);
      frameDone = 1'b0;
      mosi      = ~mosi;
      repeat (7) @(negedge clk_sys);
   endtask : xfer
endmodule : spi_host_model

/* tb/test_angle_sensor_spi_slave.sv */
`timescale 1ns/100ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin n_fail++; \
   $display("wrong value at %0t: got %h expected %h", $time, (a), (b)); end end
module test_angle_sensor_spi_slave;
   import angle_spi_pkg::*;
   localparam int CONV = 20;
   logic           clk_sys;
   logic           rst_n;
   logic           sclk;
   logic           chipSelectN;
   logic           mosi;
   logic           misoLine;
   logic           misoOut;
   logic           misoOe;
   logic           wireModeSelect;
   logic [9:0]     angleIn;
   logic           alarmHiIn;
   logic           alarmLoIn;
   logic           powerUp;
   logic           measDoneN;
   logic           frameErrorFlag;
   logic [13:0]    errorStatus;
   logic [5:0]     agcValue;
   logic [7:0]     porOffValue;
   logic [13:0]    sysConfig;
   logic           frameDone;
   logic [15:0]    rxWord;
   logic           idleBit = 1'b0;
   logic [16:0]    note;
   logic [16:0]    expQ[$];
   int             n_fail;
   int             samples_checked;

   initial clk_sys = 1'b0;
   always #5 clk_sys = ~clk_sys;
   always @(posedge clk_sys) idleBit <= ~idleBit;
   // Shared line: device, else host in 3-wire, else floating pattern
   assign misoLine = misoOe ? misoOut : (!wireModeSelect && !chipSelectN) ? mosi : idleBit;

   angle_sensor_spi_slave #(.CONV_CYCLES(CONV)) dut_u (
      .clk_sys(clk_sys), .rst_n(rst_n), .sclk(sclk), .chipSelectN(chipSelectN),
      .mosi(mosi), .misoIn(misoLine), .misoOut(misoOut), .misoOe(misoOe),
      .wireModeSelect(wireModeSelect), .angleIn(angleIn), .alarmHiIn(alarmHiIn),
      .alarmLoIn(alarmLoIn), .powerUp(powerUp), .measDoneN(measDoneN),
      .frameErrorFlag(frameErrorFlag), .errorStatus(errorStatus), .agcValue(agcValue),
      .porOffValue(porOffValue), .sysConfig(sysConfig));

   spi_host_model host_u (
      .clk_sys(clk_sys), .sclk(sclk), .chipSelectN(chipSelectN), .mosi(mosi),
      .misoLine(misoLine), .frameDone(frameDone), .rxWord(rxWord));

   function automatic logic [15:0] cmd(logic rd, logic [13:0] a);
      return {rd, a, ^{rd, a}};
   endfunction : cmd

   function automatic logic [15:0] mkWord(logic [13:0] d, logic b1);
      return {d, b1, ^{d, b1}};
   endfunction : mkWord

   task automatic report_and_stop();
      $display("comparisons %0d, mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : report_and_stop

   task automatic frame(logic [15:0] tx, logic chk, logic [15:0] exp, int nBits = 16);
      expQ.push_back({chk, exp});
      host_u.xfer(tx, nBits);
      `CHK(misoOe, 1'b0)
   endtask : frame

   task automatic waitIdle();
      int n;
      n = 0;
      while (measDoneN !== 1'b0 && n < 60) begin
         @(negedge clk_sys);
         n++;
      end
      if (measDoneN !== 1'b0) begin
         n_fail++;
         report_and_stop();
      end
   endtask : waitIdle

   // Received frames against the oldest note
   always @(posedge clk_sys) begin
      if (frameDone === 1'b1) begin
         note = expQ.pop_front();
         if (note[16]) `CHK(rxWord, note[15:0])
      end
   end

   initial begin
      logic [5:0]  v;
      logic [7:0]  p;
      logic [13:0] a1;
      logic [15:0] bad[3];
      int          bitPos[3];
      int          nb[3];
      rst_n = 1'b0;
      wireModeSelect = 1'b1;
      angleIn = '0;
      alarmHiIn = 1'b0;
      alarmLoIn = 1'b0;
      n_fail = 0;
      samples_checked = 0;
      void'($urandom(32'h830dcc76));
      repeat (20) @(negedge clk_sys);
      rst_n = 1'b1;
      repeat (4) @(negedge clk_sys);
      // Gain register write and read back
      v = 6'($urandom_range(63, 1));
      frame(cmd(1'b1, ADDR_AGC), 1'b0, '0);
      frame(cmd(1'b0, ADDR_AGC), 1'b1, mkWord(14'(AGC_RESET), 1'b0));
      frame(mkWord(14'(v), 1'b1), 1'b1, mkWord(14'(AGC_RESET), 1'b0));
      `CHK(agcValue, v)
      frame(cmd(1'b1, ADDR_AGC), 1'b1, mkWord(14'(v), 1'b0));
      frame(cmd(1'b1, ADDR_AGC), 1'b1, mkWord(14'(v), 1'b0));
      // Parity, command and clock count errors
      bad[0] = cmd(1'b1, ADDR_AGC) ^ 16'h0001;
      bad[1] = cmd(1'b1, 14'h1234);
      bad[2] = cmd(1'b1, ADDR_AGC);
      bitPos = '{ERR_PARITY_POS, ERR_COMMAND_POS, ERR_CLOCKS_POS};
      nb = '{16, 16, 15};
      for (int k = 0; k < 3; k++) begin
         frame(bad[k], nb[k] == 16, mkWord(14'(v), 1'b0), nb[k]);
         `CHK(errorStatus[bitPos[k]], 1'b1)
         `CHK(frameErrorFlag, 1'b1)
         frame(cmd(1'b1, ADDR_CLEAR_ERR), 1'b1, mkWord('0, 1'b1));
         `CHK(errorStatus, 14'h0000)
         frame(cmd(1'b1, ADDR_AGC), 1'b1, mkWord('0, 1'b0));
      end
      // Angle measurement handshake
      angleIn = 10'($urandom);
      alarmHiIn = 1'($urandom);
      alarmLoIn = 1'($urandom);
      a1 = {alarmLoIn, alarmHiIn, 2'b00, angleIn};
      frame(cmd(1'b1, ADDR_ANGLE), 1'b1, mkWord(14'(v), 1'b0));
      `CHK(measDoneN, 1'b1)
      `CHK(powerUp, 1'b1)
      `CHK(errorStatus[ERR_WOW_POS], 1'b1)
      waitIdle();
      `CHK(powerUp, 1'b0)
      @(negedge clk_sys);
      `CHK(errorStatus[ERR_WOW_POS], 1'b0)
      repeat (30) @(negedge clk_sys);
      `CHK(measDoneN, 1'b0)
      frame(cmd(1'b1, ADDR_ANGLE), 1'b0, '0);
      frame(cmd(1'b1, ADDR_AGC), 1'b1, mkWord(a1, 1'b0));
      waitIdle();
      // Dummy write command, then its data frame
      frame(cmd(1'b0, ADDR_NOP), 1'b1, mkWord(14'(v), 1'b0));
      frame(16'h0000, 1'b1, 16'h0000);
      // Power-on-reset register write, neighbours untouched
      p = 8'($urandom);
      frame(cmd(1'b0, ADDR_POR_OFF), 1'b1, 16'h0000);
      frame(mkWord(14'(p), 1'b0), 1'b1, mkWord(14'(POR_OFF_RESET), 1'b0));
      `CHK(porOffValue, p)
      `CHK(sysConfig, SYS_CONFIG_RESET)
      wireModeSelect = 1'b0;
      frame(cmd(1'b1, ADDR_AGC), 1'b0, '0);
      frame(cmd(1'b1, ADDR_AGC), 1'b1, mkWord(14'(v), 1'b0));
      report_and_stop();
   end
endmodule : test_angle_sensor_spi_slave
